// File: core/rxlp_loops.sv
// Purpose: frequency compensation and gain control loops of the receive modem
// Assumes: inputs synchronous to i_core_clk; one loop sample per i_sample_vld
// Notes: AGC attenuation code n means n times 6 dB
// Contract
// - Frequency loop runs only for FSK modulations
// - Mode bit picks slicer or IF correction
// - Estimated frequency error readable by software
// - Fast mode on power threshold, slow after period
// - Fast and slow log2 gains, 0..15
// - Fast period counts loop samples, 0..255
// - Zero period: switch gains at sync detection
// - Frequency loop runs only while enabled
// - Attenuation in 6 dB steps, max 48 dB
// - Peak amplitude compared with low and high thresholds
// - Above high: step up each hold interval
// - Below low whole measure: step down, spaced
// - Loop repeats until amplitude between thresholds
// - High threshold setting 0..15, default 5
// - Two low thresholds chosen per step
// - Measure interval is 12 times 2^setting
// - Hold interval is 12 times setting
// - Gain control runs only while enabled
// - Freeze on sync holds attenuation
`timescale 1ns/100ps
`default_nettype none
module rxlp_loops (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire rxlp_pkg::rxlp_mod_t i_mod_type,
    input wire rxlp_pkg::rxlp_afc_cfg_t i_afc_cfg,
    input wire rxlp_pkg::rxlp_agc_cfg_t i_agc_cfg,
    input wire logic i_sample_vld,
    input wire logic signed [rxlp_pkg::FREQ_W-1:0] i_demod_freq,
    input wire logic [rxlp_pkg::PWR_W-1:0] i_signal_power,
    input wire logic i_sync_found,
    input wire logic [rxlp_pkg::THR_W-1:0] i_peak_level,
    output logic signed [rxlp_pkg::FREQ_W-1:0] o_freq_error_estimate,
    output logic signed [rxlp_pkg::FREQ_W-1:0] o_slicer_offset,
    output logic signed [rxlp_pkg::FREQ_W-1:0] o_if2_offset,
    output logic o_afc_fast_mode,
    output logic [rxlp_pkg::ATT_W-1:0] o_rf_atten_step
);
    // ------------------------------------------------------------
    // Frequency compensation
    // ------------------------------------------------------------
    localparam int FW = rxlp_pkg::FREQ_W;
    localparam int AW = rxlp_pkg::ACC_W;
    logic afc_run;
    logic sync_q;
    logic started_q;
    logic started_d;
    logic fast_q;
    logic fast_d;
    logic [rxlp_pkg::FPER_W-1:0] fcnt_q;
    logic signed [FW-1:0] fmin_q;
    logic signed [FW-1:0] fmax_q;
    logic signed [FW:0] mid;
    logic signed [AW-1:0] acc_q;
    logic signed [AW-1:0] err;
    logic signed [AW-1:0] step;
    logic [rxlp_pkg::GAIN_W-1:0] gain;
    logic signed [FW-1:0] est;
    logic fsk_sel;
    logic timer_done;

    assign fsk_sel = (i_mod_type == rxlp_pkg::RXLP_MOD_2FSK) || (i_mod_type == rxlp_pkg::RXLP_MOD_4FSK);
    assign afc_run = fsk_sel && i_afc_cfg.enable;
    assign started_d = started_q || (i_signal_power > i_afc_cfg.power_thr);
    assign timer_done = (i_afc_cfg.fast_period == 8'h00) ? (sync_q || i_sync_found)
        : (fcnt_q >= i_afc_cfg.fast_period);
    assign fast_d = started_d && !timer_done;
    assign gain = fast_d ? i_afc_cfg.fast_gain : i_afc_cfg.slow_gain;
    assign mid = (FW+1)'(fmin_q) + (FW+1)'(fmax_q);
    assign err = AW'(mid) <<< (AW - FW - 1);
    assign step = err >>> gain;
    assign est = acc_q[AW-1 -: FW];

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            started_q <= 1'b0;
            sync_q <= 1'b0;
            fast_q <= 1'b0;
            fcnt_q <= '0;
            fmin_q <= '0;
            fmax_q <= '0;
            acc_q <= '0;
        end else if (!afc_run) begin
            started_q <= 1'b0;
            sync_q <= 1'b0;
            fast_q <= 1'b0;
            fcnt_q <= '0;
            acc_q <= '0;
        end else begin
            started_q <= started_d;
            sync_q <= sync_q || i_sync_found;
            fast_q <= fast_d;
            if (i_sample_vld && started_d) begin
                if (fcnt_q != 8'hFF) begin
                    fcnt_q <= fcnt_q + 8'h01;
                end
                fmin_q <= (i_demod_freq < fmin_q) ? i_demod_freq : fmin_q + 12'sh001;
                fmax_q <= (i_demod_freq > fmax_q) ? i_demod_freq : fmax_q - 12'sh001;
                acc_q <= acc_q + step;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_freq_error_estimate <= '0;
            o_slicer_offset <= '0;
            o_if2_offset <= '0;
            o_afc_fast_mode <= 1'b0;
        end else begin
            o_freq_error_estimate <= est;
            o_slicer_offset <= (afc_run && !i_afc_cfg.corr_mode) ? est : '0;
            o_if2_offset <= (afc_run && i_afc_cfg.corr_mode) ? est : '0;
            o_afc_fast_mode <= fast_q;
        end
    end

    // ------------------------------------------------------------
    // Gain control
    // ------------------------------------------------------------
    localparam int TW = rxlp_pkg::TIMER_W;
    logic [rxlp_pkg::ATT_W-1:0] att_q;
    logic [TW-1:0] hold_q;
    logic [TW-1:0] meas_q;
    logic frozen_q;
    logic agc_run;
    logic [TW-1:0] meas_len;
    logic [TW-1:0] hold_len;
    logic [rxlp_pkg::THR_W-1:0] low_thr;
    logic above_hi;
    logic below_lo;
    logic holding;
    logic do_up;
    logic do_down;

    assign agc_run = i_agc_cfg.enable && !frozen_q;
    assign meas_len = rxlp_pkg::AGC_UNIT_CYC << i_agc_cfg.meas_time;
    assign hold_len = TW'(rxlp_pkg::AGC_UNIT_CYC * TW'(i_agc_cfg.hold_time));
    assign low_thr = (att_q < 4'h8 && i_agc_cfg.low_sel[att_q[2:0]]) ? i_agc_cfg.low_thr1 : i_agc_cfg.low_thr0;
    assign above_hi = i_peak_level > i_agc_cfg.high_thr;
    assign below_lo = i_peak_level < low_thr;
    assign holding = hold_q != '0;
    assign do_up = agc_run && !holding && above_hi && (att_q < rxlp_pkg::ATT_STEPS_MAX);
    assign do_down = agc_run && !holding && below_lo && (meas_q + 20'h0_0001 >= meas_len)
        && (att_q != '0);

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            att_q <= '0;
            hold_q <= '0;
            meas_q <= '0;
            frozen_q <= 1'b0;
        end else if (!i_agc_cfg.enable) begin
            att_q <= '0;
            hold_q <= '0;
            meas_q <= '0;
            frozen_q <= 1'b0;
        end else begin
            frozen_q <= frozen_q || (i_agc_cfg.freeze_on_sync && i_sync_found);
            if (do_up || do_down) begin
                att_q <= do_up ? att_q + 4'h1 : att_q - 4'h1;
                hold_q <= hold_len;
                meas_q <= '0;
            end else if (holding) begin
                hold_q <= hold_q - 20'h0_0001;
                meas_q <= '0;
            end else begin
                meas_q <= (below_lo && agc_run) ? meas_q + 20'h0_0001 : '0;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rf_atten_step <= '0;
        end else begin
            o_rf_atten_step <= att_q;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    atten_max_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        att_q <= rxlp_pkg::ATT_STEPS_MAX) else $error("attenuation beyond maximum");
    atten_step_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_agc_cfg.enable && $changed(att_q) |-> (att_q == $past(att_q) + 4'h1) || (att_q == $past(att_q) - 4'h1)
        || (att_q == '0)) else $error("attenuation jumped more than one step");
    hold_wait_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        do_up || do_down |=> hold_q == $past(hold_len)) else $error("hold interval not loaded");
    up_cause_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_agc_cfg.enable && $past(i_agc_cfg.enable) && att_q > $past(att_q) |-> $past(above_hi) && !$past(holding))
        else $error("attenuation raised without high level");
    down_cause_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_agc_cfg.enable && $past(i_agc_cfg.enable) && att_q < $past(att_q)
        |-> $past(below_lo) && $past(meas_q) + 20'h0_0001 >= $past(meas_len))
        else $error("attenuation lowered before measure interval");
    gain_off_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        !i_agc_cfg.enable |=> att_q == '0) else $error("gain loop active while off");
    freeze_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        frozen_q && i_agc_cfg.enable ##1 i_agc_cfg.enable |-> $stable(att_q)) else $error("attenuation moved after freeze");
    afc_fsk_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        !fsk_sel ##1 1'b1 |-> o_slicer_offset == '0 && o_if2_offset == '0) else $error("frequency loop ran for AM");
    afc_mode_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        i_afc_cfg.corr_mode && afc_run |=> o_slicer_offset == '0 && o_if2_offset == $past(est))
        else $error("correction applied at wrong stage");
    afc_off_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        !i_afc_cfg.enable |=> acc_q == '0 && !fast_q) else $error("frequency loop active while off");
    afc_sync_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        afc_run && i_afc_cfg.fast_period == 8'h00 && i_sync_found |=> !fast_q) else $error("fast gain kept after sync");

    cov_up_c: cover property (@(posedge i_core_clk) disable iff (!i_rstn) do_up ##1 holding);
    cov_down_c: cover property (@(posedge i_core_clk) disable iff (!i_rstn) do_down);
    cov_fast_slow_c: cover property (@(posedge i_core_clk) disable iff (!i_rstn) fast_q ##1 !fast_q && afc_run);
    cov_freeze_c: cover property (@(posedge i_core_clk) disable iff (!i_rstn) $rose(frozen_q));
endmodule
`default_nettype wire

// File: shared/rxlp_pkg.sv
// Purpose: shared constants and carriers for the receiver frequency and gain loops
// Assumes: one digital clock domain
// Notes: all counts in loop samples or digital clock periods
package rxlp_pkg;
    localparam int GAIN_W = 4;
    localparam int FPER_W = 8;
    localparam int THR_W = 4;
    localparam int ATT_W = 4;
    localparam int LSEL_W = 8;
    localparam int PWR_W = 8;
    localparam int FREQ_W = 12;
    localparam int ACC_W = 24;
    localparam int TIMER_W = 20;
    localparam logic [ATT_W-1:0] ATT_STEPS_MAX = 4'h8;
    localparam logic [TIMER_W-1:0] AGC_UNIT_CYC = 20'h0_000C;
    localparam logic [3:0] MEAS_TIME_RST = 4'h2;
    localparam logic [7:0] HOLD_TIME_RST = 8'h0C;
    localparam logic [THR_W-1:0] HIGH_THR_RST = 4'h5;
    localparam logic [THR_W-1:0] LOW_THR0_RST = 4'h5;
    localparam logic [THR_W-1:0] LOW_THR1_RST = 4'h4;
    localparam logic [LSEL_W-1:0] LOW_SEL_RST = 8'h10;

    typedef enum logic [1:0] {
        RXLP_MOD_2FSK,
        RXLP_MOD_4FSK,
        RXLP_MOD_OOK,
        RXLP_MOD_ASK
    } rxlp_mod_t;

    typedef struct packed {
        logic enable;
        logic corr_mode;
        logic [GAIN_W-1:0] fast_gain;
        logic [GAIN_W-1:0] slow_gain;
        logic [FPER_W-1:0] fast_period;
        logic [PWR_W-1:0] power_thr;
    } rxlp_afc_cfg_t;

    typedef struct packed {
        logic enable;
        logic freeze_on_sync;
        logic [THR_W-1:0] high_thr;
        logic [THR_W-1:0] low_thr0;
        logic [THR_W-1:0] low_thr1;
        logic [LSEL_W-1:0] low_sel;
        logic [3:0] meas_time;
        logic [7:0] hold_time;
    } rxlp_agc_cfg_t;
endpackage

// File: testbench/rxlp_loops_test.sv
// Purpose: self-checking bench for the receive frequency and gain loops
// Assumes: inputs driven just after rising edges, outputs sampled on falling edges
// Notes: hold 1 and measure 0 keep the gain loop timers short
`timescale 1ns/100ps
`default_nettype none
module rxlp_loops_test;
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    rxlp_pkg::rxlp_mod_t mod_type = rxlp_pkg::RXLP_MOD_2FSK;
    rxlp_pkg::rxlp_afc_cfg_t afc_cfg = '0;
    rxlp_pkg::rxlp_agc_cfg_t agc_cfg = '0;
    logic sample_vld = 1'b0;
    logic signed [rxlp_pkg::FREQ_W-1:0] demod_freq = '0;
    logic [rxlp_pkg::PWR_W-1:0] signal_power = '0;
    logic sync_found = 1'b0;
    logic [rxlp_pkg::THR_W-1:0] peak_level = '0;
    logic signed [rxlp_pkg::FREQ_W-1:0] est, slc, if2;
    logic fast;
    logic [rxlp_pkg::ATT_W-1:0] att;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    always #4 i_core_clk = ~i_core_clk;
    rxlp_loops u_rxlp_loops (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_mod_type(mod_type),
        .i_afc_cfg(afc_cfg), .i_agc_cfg(agc_cfg), .i_sample_vld(sample_vld), .i_demod_freq(demod_freq),
        .i_signal_power(signal_power), .i_sync_found(sync_found), .i_peak_level(peak_level),
        .o_freq_error_estimate(est), .o_slicer_offset(slc), .o_if2_offset(if2),
        .o_afc_fast_mode(fast), .o_rf_atten_step(att));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_att(input logic [3:0] v, input int lim, output int cnt);
        cnt = 0;
        while (att !== v && cnt < lim) begin
            @(negedge i_core_clk);
            cnt++;
        end
        if (att !== v) chk("att_wait", 16'(v), 16'(att));
    endtask
    task automatic cycles(input int k);
        repeat (k) @(posedge i_core_clk);
    endtask
    task automatic sample(input int k);
        repeat (k) begin
            @(posedge i_core_clk);
            sample_vld <= 1'b1;
            demod_freq <= 12'h0C8;
        end
        @(posedge i_core_clk);
        sample_vld <= 1'b0;
        repeat (3) @(negedge i_core_clk);
    endtask
    task automatic pulse_sync();
        @(posedge i_core_clk);
        sync_found <= 1'b1;
        @(posedge i_core_clk);
        sync_found <= 1'b0;
    endtask
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        cycles(4);
        i_rstn <= 1'b1;
        @(negedge i_core_clk);
        chk("att_reset", 16'h0000, 16'(att));
        @(posedge i_core_clk);
        agc_cfg <= '{enable: 1'b1, freeze_on_sync: 1'b0, high_thr: rxlp_pkg::HIGH_THR_RST,
            low_thr0: rxlp_pkg::LOW_THR0_RST, low_thr1: rxlp_pkg::LOW_THR1_RST,
            low_sel: rxlp_pkg::LOW_SEL_RST, meas_time: 4'h0, hold_time: 8'h01};
        peak_level <= 4'h9;
        wait_att(4'h1, 10, n);
        wait_att(4'h2, 40, n);
        chk("up_gap", 16'h000D, 16'(n));
        wait_att(4'h8, 200, n);
        repeat (40) @(negedge i_core_clk);
        chk("att_max", 16'(rxlp_pkg::ATT_STEPS_MAX), 16'(att));
        @(posedge i_core_clk);
        peak_level <= 4'h5;
        repeat (100) @(negedge i_core_clk);
        chk("att_between", 16'h0008, 16'(att));
        @(posedge i_core_clk);
        peak_level <= 4'h4;
        wait_att(4'h4, 200, n);
        repeat (100) @(negedge i_core_clk);
        chk("att_low_sel", 16'h0004, 16'(att));
        @(posedge i_core_clk);
        peak_level <= 4'h0;
        wait_att(4'h3, 100, n);
        wait_att(4'h2, 100, n);
        chk("down_gap", 16'h0018, 16'(n));
        wait_att(4'h0, 400, n);
        repeat (60) @(negedge i_core_clk);
        chk("att_min", 16'h0000, 16'(att));
        @(posedge i_core_clk);
        agc_cfg.freeze_on_sync <= 1'b1;
        pulse_sync();
        peak_level <= 4'h9;
        repeat (60) @(negedge i_core_clk);
        chk("att_frozen", 16'h0000, 16'(att));
        @(posedge i_core_clk);
        agc_cfg.enable <= 1'b0;
        agc_cfg.freeze_on_sync <= 1'b0;
        cycles(2);
        agc_cfg.enable <= 1'b1;
        wait_att(4'h1, 10, n);
        @(posedge i_core_clk);
        agc_cfg.enable <= 1'b0;
        repeat (4) @(negedge i_core_clk);
        chk("att_disabled", 16'h0000, 16'(att));
        @(posedge i_core_clk);
        afc_cfg <= '{enable: 1'b1, corr_mode: 1'b0, fast_gain: 4'h0, slow_gain: 4'hF,
            fast_period: 8'h04, power_thr: 8'h32};
        signal_power <= 8'h0A;
        sample(2);
        chk("fast_low_power", 16'h0000, 16'(fast));
        @(posedge i_core_clk);
        signal_power <= 8'h64;
        sample(1);
        chk("fast_start", 16'h0001, 16'(fast));
        sample(6);
        chk("fast_end", 16'h0000, 16'(fast));
        chk("est_nonzero", 16'h0001, 16'(est != 0));
        chk("slicer_mode0", 16'(est), 16'(slc));
        chk("if2_mode0", 16'h0000, 16'(if2));
        @(posedge i_core_clk);
        afc_cfg.corr_mode <= 1'b1;
        sample(1);
        chk("if2_mode1", 16'(est), 16'(if2));
        chk("slicer_mode1", 16'h0000, 16'(slc));
        for (int m = 2; m < 4; m++) begin
            @(posedge i_core_clk);
            mod_type <= rxlp_pkg::rxlp_mod_t'(m);
            sample(2);
            chk("am_fast", 16'h0000, 16'(fast));
            chk("am_offset", 16'h0000, 16'(slc | if2));
        end
        @(posedge i_core_clk);
        mod_type <= rxlp_pkg::RXLP_MOD_4FSK;
        afc_cfg.fast_period <= 8'h00;
        sample(8);
        chk("fast_before_sync", 16'h0001, 16'(fast));
        pulse_sync();
        repeat (4) @(negedge i_core_clk);
        chk("fast_after_sync", 16'h0000, 16'(fast));
        @(posedge i_core_clk);
        afc_cfg.enable <= 1'b0;
        sample(2);
        chk("off_offset", 16'h0000, 16'(slc | if2 | 12'(fast)));
        final_report();
    end
endmodule
`default_nettype wire
